// >>> rtl/sram_rtc_defs.svh
// Purpose: Named constants for the two-wire memory and clock slave.
// Assumes: Included by bare name; the clock runs at 250 MHz.
// Notes: Times are kept in their own unit; cycle counts derive from them.
`ifndef SRAM_RTC_DEFS_SVH
`define SRAM_RTC_DEFS_SVH

// Clock period of ref_clk in nanoseconds.
`define CLK_PERIOD_NS 4
// Recovery delay after the supply returns, in nanoseconds (plain default).
`define REC_TIME_NS 1000000
// Fixed slave address byte with the direction bit cleared.
`define SLAVE_ADDR 8'hd0
// Bits in one byte on the bus.
`define BITS_PER_BYTE 4'h8
// Byte index at which data bytes begin after the two address bytes.
`define IDX_PTR_HI 2'h1
`define IDX_PTR_LO 2'h2
`define IDX_DATA 2'h3
// First address of the timekeeping bytes that survive sleep mode.
`define CLOCK_BASE 15'h7ff0
// Control byte holding the sleep arm bit.
`define CTRL_ADDR 15'h7ff8
// Seconds byte holding the oscillator stop bit.
`define SEC_ADDR 15'h7ff9
// Bit positions within those bytes.
`define SLEEP_BIT 6
`define OSC_STOP_BIT 7
// Value returned from the general array after sleep isolated it.
`define LOST_BYTE 8'hff

`endif

// >>> rtl/sram_rtc_pkg.sv
// Purpose: Types shared by the two-wire memory and clock slave.
// Assumes: Used by scoped names only; nothing is imported.
// Notes: Constants live in the defs header.
package sram_rtc_pkg;

    // Bus engine states.
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_RX    = 3'b010,
        ST_ACK   = 3'b011,
        ST_TX    = 3'b100,
        ST_TXACK = 3'b101
    } bus_state_t;

    // Bus pins as seen from the outside.
    typedef struct packed {
        logic scl;
        logic sda;
    } bus_in_t;

    // Open-drain data pin drive.
    typedef struct packed {
        logic sda_o;
        logic sda_oe;
    } bus_out_t;

    // Supply monitor inputs.
    typedef struct packed {
        logic power_fail;
        logic on_battery;
    } supply_t;

    // All state of the main domain except the recovery counter and the memory array.
    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_d;
        logic sda_s1;
        logic sda_s2;
        logic sda_d;
        logic pf_s1;
        logic pf_s2;
        logic bat_s1;
        logic bat_s2;
        logic bat_d;
        bus_state_t st;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [1:0] idx;
        logic rw;
        logic acked;
        logic [14:0] ptr;
        logic sda_oe;
        logic sda_o;
        logic rst_oe;
        logic rst_o;
        logic sleep_arm;
        logic osc_stop;
        logic ram_lost;
    } core_state_t;

    // All state of the oscillator domain.
    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic stop_s1;
        logic stop_s2;
        logic running;
    } osc_state_t;

endpackage

// >>> rtl/sram_rtc_slave.sv
// Purpose: Two-wire slave for a 32K x 8 battery-backed memory with clock bytes.
// Assumes: Pins and supply flags are asynchronous and are synchronised here.
// Notes: Clock counting, calibration and tamper logic are not included.
// Function
// - Ninth clock after each byte carries acknowledge.
// - Acknowledge every byte received when addressed.
// - Hold data low through acknowledge high phase.
// - Release data line after unacknowledged byte.
// - Random read loads pointer, first MSB ignored.
// - Repeated start with read sends pointed byte.
// - Read pointer advances only on acknowledge.
// - Sequential reads continue until stop.
// - Pointer wraps from top to bottom.
// - Plain read starts at current pointer.
// - Write sends address then two pointer bytes.
// - Store data byte, advance pointer at acknowledge.
// - Acknowledge slave address and both address bytes.
// - Power fail deselects and blocks all access.
// - Reset output active during power fail.
// - Protection and reset persist for recovery delay.
// - On battery every output is high impedance.
// - Sleep bit write only arms a latch.
// - Armed sleep at switchover loses general memory.
// - Oscillator stop bit halts the oscillator.
// - Respond only to matching address after start.
// - Power fail aborts access, clears pointer.
`timescale 1ns/100ps
`include "sram_rtc_defs.svh"

module sram_rtc_slave #(
    parameter int ADDR_W = 15,
    parameter int REC_W = 24,
    parameter int REC_CYCLES = `REC_TIME_NS / `CLK_PERIOD_NS
) (
    // Main clock and synchronous reset.
    input logic ref_clk,
    input logic rst,
    // Oscillator domain clock.
    input logic osc_clk,
    // Two-wire bus pins.
    input sram_rtc_pkg::bus_in_t bus_in,
    output sram_rtc_pkg::bus_out_t bus_out,
    // Supply monitor flags.
    input sram_rtc_pkg::supply_t supply,
    // Open-drain reset output pin.
    output logic rst_pin_o,
    output logic rst_pin_oe,
    // Oscillator status.
    output logic osc_running
);

    // Current and next state of the main domain.
    sram_rtc_pkg::core_state_t s_r;
    sram_rtc_pkg::core_state_t s_nxt;
    // Recovery counter, kept apart so its width follows the parameter.
    logic [REC_W-1:0] rec_r;
    logic [REC_W-1:0] rec_nxt;
    // Memory array in flip-flops, addressed by the pointer.
    logic [7:0] mem [0:(1<<ADDR_W)-1];
    // Memory write request computed by the combinational process.
    logic mem_we;
    logic [14:0] mem_wa;
    logic [7:0] mem_wd;
    // Byte at the pointer, with sleep loss applied.
    logic [7:0] rd_byte;
    // Decoded bus events on the synchronised lines.
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    // Access is blocked while the supply is bad or recovering.
    logic protect;
    // Oscillator domain state.
    sram_rtc_pkg::osc_state_t o_r;
    sram_rtc_pkg::osc_state_t o_nxt;

    // Edges are taken only from the second stages and their delayed copies.
    assign scl_rise = s_r.scl_s2 & ~s_r.scl_d;
    assign scl_fall = ~s_r.scl_s2 & s_r.scl_d;
    assign start_det = s_r.scl_s2 & s_r.scl_d & s_r.sda_d & ~s_r.sda_s2;
    assign stop_det = s_r.scl_s2 & s_r.scl_d & ~s_r.sda_d & s_r.sda_s2;
    assign protect = s_r.pf_s2 | (rec_r != '0);

    // Reads of the general array return a fixed byte once sleep isolated it.
    always_comb
    begin
        rd_byte = mem[s_r.ptr];
        if (s_r.ram_lost && (s_r.ptr < `CLOCK_BASE))
        begin
            rd_byte = `LOST_BYTE;
        end
    end

    // Next-state logic for synchronisers, supply handling and the bus engine.
    always_comb
    begin
        s_nxt = s_r;
        rec_nxt = rec_r;
        mem_we = 1'b0;
        mem_wa = s_r.ptr;
        mem_wd = s_r.shift;
        // Two-stage synchronisers; the first stage feeds only the second.
        s_nxt.scl_s1 = bus_in.scl;
        s_nxt.scl_s2 = s_r.scl_s1;
        s_nxt.scl_d = s_r.scl_s2;
        s_nxt.sda_s1 = bus_in.sda;
        s_nxt.sda_s2 = s_r.sda_s1;
        s_nxt.sda_d = s_r.sda_s2;
        s_nxt.pf_s1 = supply.power_fail;
        s_nxt.pf_s2 = s_r.pf_s1;
        s_nxt.bat_s1 = supply.on_battery;
        s_nxt.bat_s2 = s_r.bat_s1;
        s_nxt.bat_d = s_r.bat_s2;
        // The recovery delay restarts on every power-fail cycle.
        if (s_r.pf_s2)
        begin
            rec_nxt = REC_W'(REC_CYCLES);
        end
        else if (rec_r != '0)
        begin
            rec_nxt = rec_r - REC_W'(1);
        end
        // Reset pin low while protected, but floated on battery.
        s_nxt.rst_oe = protect & ~s_r.bat_s2;
        // Sleep engages at the switchover edge; the arm bit itself stays set.
        if (s_r.bat_s2 && !s_r.bat_d && s_r.sleep_arm)
        begin
            s_nxt.ram_lost = 1'b1;
        end
        if (protect)
        begin
            // Deselect and abort, clearing the pointer only during power fail; nothing reaches memory.
            s_nxt.st = sram_rtc_pkg::ST_IDLE;
            s_nxt.sda_oe = 1'b0;
            if (s_r.pf_s2)
            begin
                s_nxt.ptr = '0;
            end
        end
        else if (start_det)
        begin
            // Any start, repeated or not, begins a new address byte.
            s_nxt.st = sram_rtc_pkg::ST_ADDR;
            s_nxt.bit_cnt = 4'h0;
            s_nxt.idx = 2'h0;
            s_nxt.sda_oe = 1'b0;
        end
        else if (stop_det)
        begin
            s_nxt.st = sram_rtc_pkg::ST_IDLE;
            s_nxt.sda_oe = 1'b0;
        end
        else
        begin
            case (s_r.st)
                sram_rtc_pkg::ST_ADDR, sram_rtc_pkg::ST_RX:
                begin
                    // Shift in on the rising edge while the line is stable.
                    if (scl_rise && (s_r.bit_cnt != `BITS_PER_BYTE))
                    begin
                        s_nxt.shift = {s_r.shift[6:0], s_r.sda_s2};
                        s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                    end
                    else if (scl_fall && (s_r.bit_cnt == `BITS_PER_BYTE))
                    begin
                        s_nxt.bit_cnt = 4'h0;
                        if (s_r.st == sram_rtc_pkg::ST_ADDR)
                        begin
                            // Only the fixed address is answered.
                            if (s_r.shift[7:1] == 7'(`SLAVE_ADDR >> 1))
                            begin
                                s_nxt.rw = s_r.shift[0];
                                s_nxt.idx = `IDX_PTR_HI;
                                s_nxt.st = sram_rtc_pkg::ST_ACK;
                                s_nxt.sda_oe = 1'b1;
                            end
                            else
                            begin
                                s_nxt.st = sram_rtc_pkg::ST_IDLE;
                            end
                        end
                        else
                        begin
                            // Every byte taken in is acknowledged.
                            s_nxt.st = sram_rtc_pkg::ST_ACK;
                            s_nxt.sda_oe = 1'b1;
                            if (s_r.idx == `IDX_PTR_HI)
                            begin
                                s_nxt.ptr[14:8] = s_r.shift[6:0];
                                s_nxt.idx = `IDX_PTR_LO;
                            end
                            else if (s_r.idx == `IDX_PTR_LO)
                            begin
                                s_nxt.ptr[7:0] = s_r.shift;
                                s_nxt.idx = `IDX_DATA;
                            end
                            else
                            begin
                                // Store, then step the pointer; it wraps naturally.
                                mem_we = 1'b1;
                                s_nxt.ptr = s_r.ptr + 15'h1;
                                if (s_r.ptr == `CTRL_ADDR)
                                begin
                                    s_nxt.sleep_arm = s_r.shift[`SLEEP_BIT];
                                end
                                if (s_r.ptr == `SEC_ADDR)
                                begin
                                    s_nxt.osc_stop = s_r.shift[`OSC_STOP_BIT];
                                end
                            end
                        end
                    end
                end
                sram_rtc_pkg::ST_ACK:
                begin
                    // The low level is held until the acknowledge clock falls.
                    if (scl_fall)
                    begin
                        if (s_r.rw)
                        begin
                            // Read: send the byte at the current pointer.
                            s_nxt.shift = rd_byte;
                            s_nxt.sda_oe = ~rd_byte[7];
                            s_nxt.st = sram_rtc_pkg::ST_TX;
                        end
                        else
                        begin
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.st = sram_rtc_pkg::ST_RX;
                        end
                    end
                end
                sram_rtc_pkg::ST_TX:
                begin
                    // Change data only while the clock is low.
                    if (scl_fall)
                    begin
                        if (s_r.bit_cnt == `BITS_PER_BYTE - 4'h1)
                        begin
                            s_nxt.bit_cnt = 4'h0;
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.st = sram_rtc_pkg::ST_TXACK;
                        end
                        else
                        begin
                            s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                            s_nxt.shift = {s_r.shift[6:0], 1'b0};
                            s_nxt.sda_oe = ~s_r.shift[6];
                        end
                    end
                end
                sram_rtc_pkg::ST_TXACK:
                begin
                    // Sample the master's answer at the ninth clock.
                    if (scl_rise)
                    begin
                        s_nxt.acked = ~s_r.sda_s2;
                        if (!s_r.sda_s2)
                        begin
                            s_nxt.ptr = s_r.ptr + 15'h1;
                        end
                    end
                    else if (scl_fall)
                    begin
                        if (s_r.acked)
                        begin
                            s_nxt.shift = rd_byte;
                            s_nxt.sda_oe = ~rd_byte[7];
                            s_nxt.st = sram_rtc_pkg::ST_TX;
                        end
                        else
                        begin
                            // Leave the line high so the master can stop.
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.st = sram_rtc_pkg::ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    s_nxt.sda_oe = 1'b0;
                end
            endcase
        end
        // Battery operation floats every pin regardless of the engine.
        if (s_r.bat_s2)
        begin
            s_nxt.sda_oe = 1'b0;
        end
    end

    // Register the main domain; the reset holds the host in reset first.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.scl_s1 <= 1'b1;
            s_r.scl_s2 <= 1'b1;
            s_r.scl_d <= 1'b1;
            s_r.sda_s1 <= 1'b1;
            s_r.sda_s2 <= 1'b1;
            s_r.sda_d <= 1'b1;
            s_r.st <= sram_rtc_pkg::ST_IDLE;
            rec_r <= REC_W'(REC_CYCLES);
        end
        else
        begin
            s_r <= s_nxt;
            rec_r <= rec_nxt;
        end
    end

    // Memory writes; contents are not cleared by reset, as in a real array.
    always_ff @(posedge ref_clk)
    begin
        if (mem_we)
        begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // Oscillator domain: reset and stop bit each cross through two stages.
    always_comb
    begin
        o_nxt = o_r;
        o_nxt.rst_s1 = rst;
        o_nxt.rst_s2 = o_r.rst_s1;
        o_nxt.stop_s1 = s_r.osc_stop;
        o_nxt.stop_s2 = o_r.stop_s1;
        o_nxt.running = ~o_r.stop_s2;
        if (o_r.rst_s2)
        begin
            o_nxt.running = 1'b0;
        end
    end

    // Register the oscillator domain.
    always_ff @(posedge osc_clk)
    begin
        o_r <= o_nxt;
    end

    // Every output comes straight from a flip-flop.
    assign bus_out.sda_o = s_r.sda_o;
    assign bus_out.sda_oe = s_r.sda_oe;
    assign rst_pin_o = s_r.rst_o;
    assign rst_pin_oe = s_r.rst_oe;
    assign osc_running = o_r.running;

    // Checks on the main domain.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    ack_hold_a: assert property ((s_r.st == sram_rtc_pkg::ST_ACK) |-> bus_out.sda_oe)
        else $error("Acknowledge not driven low.");
    addr_ack_a: assert property ((s_r.st == sram_rtc_pkg::ST_ADDR && scl_fall && !protect
        && !start_det && !stop_det && s_r.bit_cnt == 4'h8 && s_r.shift[7:1] == 7'h68)
        |=> (s_r.st == sram_rtc_pkg::ST_ACK) ##1 bus_out.sda_oe)
        else $error("Matching address not acknowledged.");
    wrong_addr_a: assert property ((s_r.st == sram_rtc_pkg::ST_ADDR && scl_fall && !protect
        && !start_det && !stop_det && s_r.bit_cnt == 4'h8 && s_r.shift[7:1] != 7'h68)
        |=> (s_r.st == sram_rtc_pkg::ST_IDLE) && !s_r.sda_oe)
        else $error("Foreign address answered.");
    nack_release_a: assert property ((s_r.st == sram_rtc_pkg::ST_TXACK && scl_fall
        && !s_r.acked && !protect && !start_det && !stop_det)
        |=> !s_r.sda_oe ##1 !bus_out.sda_oe)
        else $error("Data line held after no acknowledge.");
    ptr_step_a: assert property ((s_r.st == sram_rtc_pkg::ST_TXACK && scl_rise
        && !s_r.sda_s2 && !protect && !start_det && !stop_det)
        |=> s_r.ptr == $past(s_r.ptr) + 15'h1)
        else $error("Read pointer did not advance.");
    ptr_hi_a: assert property ((s_r.st == sram_rtc_pkg::ST_RX && scl_fall && !protect
        && !start_det && !stop_det && s_r.bit_cnt == 4'h8 && s_r.idx == 2'h1)
        |=> s_r.ptr[14:8] == $past(s_r.shift[6:0]))
        else $error("High pointer byte loaded wrongly.");
    wrap_a: assert property ((s_r.st == sram_rtc_pkg::ST_TXACK && scl_rise
        && !s_r.sda_s2 && !protect && !start_det && !stop_det && s_r.ptr == 15'h7fff)
        |=> s_r.ptr == 15'h0)
        else $error("Pointer failed to wrap.");
    deselect_a: assert property (s_r.pf_s2 |=> (s_r.st == sram_rtc_pkg::ST_IDLE)
        && s_r.ptr == 15'h0 && !mem_we)
        else $error("Access not aborted on power fail.");
    reset_pin_a: assert property ((s_r.pf_s2 && !s_r.bat_s2) |=> rst_pin_oe)
        else $error("Reset output not driven on power fail.");
    rec_block_a: assert property ((rec_r != '0) |-> !mem_we)
        else $error("Memory written during recovery delay.");
    recovery_a: assert property ($fell(s_r.pf_s2) && !s_r.bat_s2 |=> rst_pin_oe [*2])
        else $error("Reset released before recovery delay.");
    battery_float_a: assert property (s_r.bat_s2 |=> !bus_out.sda_oe && !rst_pin_oe)
        else $error("Output driven while on battery.");
    stop_idle_a: assert property ((stop_det && !start_det && !protect)
        |=> s_r.st == sram_rtc_pkg::ST_IDLE)
        else $error("Stop did not return to idle.");

    read_ack_c: cover property (s_r.st == sram_rtc_pkg::ST_TXACK && scl_rise && !s_r.sda_s2);
    write_data_c: cover property (mem_we);
    nack_end_c: cover property (s_r.st == sram_rtc_pkg::ST_TXACK && scl_fall && !s_r.acked);
    sleep_engage_c: cover property ($rose(s_r.ram_lost));

endmodule

// >>> verif/i2c_master_model.sv
// Purpose: Bus master model that clocks the two-wire memory and clock slave.
// Assumes: Paced by ref_clk falling edges; the data line has a pull-up.
// Notes: The bus clock stands high between frames, as a real master leaves it.
`timescale 1ns/100ps

module i2c_master_model (
    // Pacing clock.
    input wire logic ref_clk,
    // Resolved data line.
    input wire logic sda,
    // Bus clock level and data pull-down.
    output logic scl,
    output logic sda_low
);
    // Quarter bit time; keeps each low phase well above the slave's sampling need.
    localparam int QTR = 8;

    // Bus idles released at time zero.
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Waits one quarter bit time.
    task automatic qtr();
        repeat (QTR) @(negedge ref_clk);
    endtask

    // Start or repeated start: data falls while the clock is high.
    task automatic start();
        sda_low = 1'b0;
        qtr();
        scl = 1'b1;
        qtr();
        sda_low = 1'b1;
        qtr();
        scl = 1'b0;
    endtask

    // Stop, then the bus stays free for the idle gap before any new start.
    task automatic stop();
        sda_low = 1'b1;
        qtr();
        scl = 1'b1;
        qtr();
        sda_low = 1'b0;
        repeat (325) @(negedge ref_clk);
    endtask

    // Nine clocks: eight bits MSB first, then acknowledge; a one releases the line.
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--)
        begin
            sda_low = ~tx[i];
            qtr();
            scl = 1'b1;
            qtr();
            rx[i] = sda;
            qtr();
            scl = 1'b0;
            qtr();
        end
    endtask
endmodule

// >>> verif/test_i2c_sram_rtc_slave_access.sv
// Purpose: Self-checking bench for the two-wire memory and clock slave.
// Assumes: Recovery delay shortened to REC cycles; fixed random seed.
// Notes: Only addresses written earlier are read back and compared.
`timescale 1ns/100ps
`include "sram_rtc_defs.svh"

module test_i2c_sram_rtc_slave_access;
    // Shortened recovery count so power cycles stay brief.
    localparam int REC = 20;
    logic ref_clk = 1'b0;
    logic osc_clk = 1'b0;
    logic rst = 1'b1;
    sram_rtc_pkg::supply_t supply = '0;
    sram_rtc_pkg::bus_in_t bus_in;
    sram_rtc_pkg::bus_out_t bus_out;
    logic scl, sda_low, sda, rst_pin_o, rst_pin_oe, osc_running;
    logic [7:0] exp_mem [0:32767];
    logic [14:0] ptr, a;
    logic [8:0] rx;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;
    int seed = 32'hb3654442;

    // Open-drain wire: either party pulls low, the pull-up wins otherwise.
    assign sda = ~(sda_low | bus_out.sda_oe);
    assign bus_in = {scl, sda};

    sram_rtc_slave #(.REC_CYCLES(REC)) u_sram_rtc_slave (
        .ref_clk(ref_clk), .rst(rst), .osc_clk(osc_clk), .bus_in(bus_in),
        .bus_out(bus_out), .supply(supply), .rst_pin_o(rst_pin_o),
        .rst_pin_oe(rst_pin_oe), .osc_running(osc_running));

    i2c_master_model u_i2c_master_model (
        .ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(sda_low));

    // Main clock, 4 ns period.
    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end

    // Oscillator clock, 32 ns period, offset so its phase is unrelated.
    initial
    begin
        #7.3;
        forever #16 osc_clk = ~osc_clk;
    end

    // Compares one byte-wide result and counts it.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Expected read byte at one address, with the sleep loss applied.
    function automatic logic [7:0] exp_byte(input logic [14:0] p, input bit lost);
        return (lost && p < `CLOCK_BASE) ? `LOST_BYTE : exp_mem[p];
    endfunction

    // Write of n bytes from address wa; ok says whether the slave should answer.
    task automatic wr(input logic [14:0] wa, input int cnt, input logic [7:0] v,
                      input bit rnd, input logic ok);
        logic [7:0] d;
        u_i2c_master_model.start();
        u_i2c_master_model.xfer({`SLAVE_ADDR, 1'b1}, rx);
        chk({7'h00, rx[0]}, {7'h00, ~ok});
        // The top pointer bit goes out random, since the slave must ignore it.
        u_i2c_master_model.xfer({1'($random(seed)), wa[14:8], 1'b1}, rx);
        chk({7'h00, rx[0]}, {7'h00, ~ok});
        u_i2c_master_model.xfer({wa[7:0], 1'b1}, rx);
        chk({7'h00, rx[0]}, {7'h00, ~ok});
        for (int k = 0; k < cnt; k++)
        begin
            d = rnd ? 8'($random(seed)) : v;
            u_i2c_master_model.xfer({d, 1'b1}, rx);
            chk({7'h00, rx[0]}, {7'h00, ~ok});
            if (ok)
                exp_mem[wa + 15'(k)] = d;
        end
        if (ok)
            ptr = wa + 15'(cnt);
        u_i2c_master_model.stop();
    endtask

    // Read of cnt bytes, optionally loading the pointer first; lost marks sleep loss.
    task automatic rd(input bit set, input logic [14:0] ra, input int cnt, input bit lost);
        logic [7:0] e;
        if (set)
        begin
            u_i2c_master_model.start();
            u_i2c_master_model.xfer({`SLAVE_ADDR, 1'b1}, rx);
            u_i2c_master_model.xfer({1'b1, ra[14:8], 1'b1}, rx);
            u_i2c_master_model.xfer({ra[7:0], 1'b1}, rx);
            ptr = ra;
        end
        u_i2c_master_model.start();
        u_i2c_master_model.xfer({`SLAVE_ADDR | 8'h01, 1'b1}, rx);
        chk({7'h00, rx[0]}, 8'h00);
        for (int k = 0; k < cnt; k++)
        begin
            // Last byte is refused by the master to end the read.
            u_i2c_master_model.xfer({8'hff, k == cnt - 1}, rx);
            e = exp_byte(ptr, lost);
            chk(rx[8:1], e);
            if (k != cnt - 1)
                ptr = ptr + 15'h0001;
        end
        chk({7'h00, bus_out.sda_oe}, 8'h00);
        u_i2c_master_model.stop();
    endtask

    // Power loss and return; bat also takes the device down to the battery.
    task automatic supply_cycle(input bit bat);
        supply.power_fail = 1'b1;
        repeat (8) @(negedge ref_clk);
        chk({7'h00, rst_pin_oe}, 8'h01);
        // Open-drain pins carry a low level whenever they are enabled.
        chk({6'h00, rst_pin_o, bus_out.sda_o}, 8'h00);
        wr(15'h0123, 1, 8'h5a, 1'b0, 1'b0);
        if (bat)
        begin
            supply.on_battery = 1'b1;
            repeat (8) @(negedge ref_clk);
            chk({6'h00, rst_pin_oe, bus_out.sda_oe}, 8'h00);
            supply.on_battery = 1'b0;
        end
        supply.power_fail = 1'b0;
        repeat (REC - 2) @(negedge ref_clk);
        chk({7'h00, rst_pin_oe}, 8'h01);
        repeat (12) @(negedge ref_clk);
        chk({7'h00, rst_pin_oe}, 8'h00);
        ptr = '0;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Cuts a hang short well beyond the expected run length.
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 80000)
        begin
            n_errors++;
            complete_run();
        end
    end

    // Main sequence.
    initial
    begin
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk({7'h00, rst_pin_oe}, 8'h01);
        repeat (REC + 8) @(negedge ref_clk);
        chk({7'h00, rst_pin_oe}, 8'h00);
        // Random bursts, then a current-address read of the last byte.
        repeat (3)
        begin
            a = 15'($random(seed)) & 15'h3fff;
            n = 2 + ($random(seed) & 3);
            wr(a, n, 8'h00, 1'b1, 1'b1);
            rd(1'b1, a, n, 1'b0);
            rd(1'b0, a, 1, 1'b0);
        end
        wr(15'h7fff, 2, 8'h00, 1'b1, 1'b1);
        rd(1'b1, 15'h7fff, 2, 1'b0);
        // A foreign address must go unanswered.
        u_i2c_master_model.start();
        u_i2c_master_model.xfer({8'ha0, 1'b1}, rx);
        chk({7'h00, rx[0]}, 8'h01);
        u_i2c_master_model.stop();
        wr(`SEC_ADDR, 1, 8'h80, 1'b0, 1'b1);
        chk({7'h00, osc_running}, 8'h00);
        wr(`SEC_ADDR, 1, 8'h00, 1'b0, 1'b1);
        chk({7'h00, osc_running}, 8'h01);
        // A known byte that the refused write during power fail must leave alone.
        wr(15'h0123, 1, 8'ha5, 1'b0, 1'b1);
        supply_cycle(1'b0);
        rd(1'b0, 15'h0000, 1, 1'b0);
        rd(1'b1, 15'h0123, 1, 1'b0);
        wr(`CTRL_ADDR, 1, 8'h40, 1'b0, 1'b1);
        rd(1'b1, a, 1, 1'b0);
        supply_cycle(1'b1);
        rd(1'b1, a, 1, 1'b1);
        rd(1'b1, `CTRL_ADDR, 1, 1'b1);
        complete_run();
    end
endmodule
